// ===== hdl/dmrc_top.v
// remap decoder and switchable ram banks
`timescale 1ns/10ps
`default_nettype none
`include "dmrc_defines.vh"
//
// Contract
// - remapped ram banks keep their stored words across every switch
// - configuration changes at run time when the enable bits are written
// - only program 0200-0AFF, X 0C00-11FF, Y 0E00-10FF are remapped
// - new map applies three instruction cycles after the enable write
// - enable a maps X 0C00-0EFF onto program 0800-0AFF
// - reset clears the enable bits
module dmrc_top
(
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        instr_cycle_en,
  input  wire        omr_wr,
  input  wire [23:0] omr_wdata,
  output reg  [1:0]  operating_mode_reg_pe_q,
  output reg  [1:0]  map_active_q,
  output wire        switch_pending,
  input  wire [15:0] p_addr,
  input  wire        p_rd,
  input  wire        p_wr,
  input  wire [23:0] p_wdata,
  output reg  [23:0] p_rdata_q,
  output reg         p_hit_q,
  input  wire [15:0] x_addr,
  input  wire        x_rd,
  input  wire        x_wr,
  input  wire [23:0] x_wdata,
  output reg  [23:0] x_rdata_q,
  output reg         x_hit_q,
  input  wire [15:0] y_addr,
  input  wire        y_rd,
  input  wire        y_wr,
  input  wire [23:0] y_wdata,
  output reg  [23:0] y_rdata_q,
  output reg         y_hit_q
);
  reg  [1:0]  cnt_q;
  reg         busy_q;
  wire [71:0] bank_rd;
  wire [2:0]  use_p;
  wire [2:0]  use_x;
  wire [2:0]  use_y;
  reg  [2:0]  psel_q;
  reg  [2:0]  xsel_q;
  reg  [2:0]  ysel_q;
  reg  [23:0] p_mux;
  reg  [23:0] x_mux;
  reg  [23:0] y_mux;
  integer     i;

  assign switch_pending = busy_q;

  // enable bits and delayed map register
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      operating_mode_reg_pe_q <= `DMRC_PE_RST;
      map_active_q            <= `DMRC_PE_RST;
      cnt_q                   <= 2'h0;
      busy_q                  <= 1'b0;
    end
    else if (omr_wr)
    begin
      operating_mode_reg_pe_q <= {omr_wdata[`DMRC_PE_B_BIT], omr_wdata[`DMRC_PE_A_BIT]};
      cnt_q                   <= 2'h0;
      busy_q                  <= 1'b1;
    end
    else if (busy_q && instr_cycle_en)
    begin
      if (cnt_q == `DMRC_SWITCH_CYC - 2'h1)
      begin
        map_active_q <= operating_mode_reg_pe_q;
        busy_q       <= 1'b0;
      end
      else
        cnt_q <= cnt_q + 2'h1;
    end
  end

  // per-bank routing: 0 x-a, 1 x-b, 2 y-b
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : bank
      reg  [15:0] p_lo;
      reg  [15:0] p_hi;
      reg  [15:0] d_lo;
      reg  [15:0] d_hi;
      reg  [15:0] d_adr;
      reg         d_rd;
      reg         d_wr;
      reg  [23:0] d_wd;
      // window and data bus of this bank
      always @*
      begin
        case (g)
          0:
          begin
            p_lo  = `DMRC_P_A_LO;
            p_hi  = `DMRC_P_A_HI;
            d_lo  = `DMRC_X_A_LO;
            d_hi  = `DMRC_X_A_HI;
            d_adr = x_addr;
            d_rd  = x_rd;
            d_wr  = x_wr;
            d_wd  = x_wdata;
          end
          1:
          begin
            p_lo  = `DMRC_P_B1_LO;
            p_hi  = `DMRC_P_B1_HI;
            d_lo  = `DMRC_X_B_LO;
            d_hi  = `DMRC_X_B_HI;
            d_adr = x_addr;
            d_rd  = x_rd;
            d_wr  = x_wr;
            d_wd  = x_wdata;
          end
          default:
          begin
            p_lo  = `DMRC_P_B2_LO;
            p_hi  = `DMRC_P_B2_HI;
            d_lo  = `DMRC_Y_B_LO;
            d_hi  = `DMRC_Y_B_HI;
            d_adr = y_addr;
            d_rd  = y_rd;
            d_wr  = y_wr;
            d_wd  = y_wdata;
          end
        endcase
      end
      // map bit a steers bank 0, map bit b steers banks 1 and 2
      wire        to_p  = (g == 0) ? map_active_q[0] : map_active_q[1];
      wire        in_p  = (p_addr >= p_lo) && (p_addr <= p_hi);
      wire        in_d  = (d_adr >= d_lo) && (d_adr <= d_hi);
      wire        sp    = to_p && in_p && (p_rd || p_wr);
      wire        sd    = !to_p && in_d && (d_rd || d_wr);
      wire [15:0] p_off = p_addr - p_lo;
      wire [15:0] d_off = d_adr - d_lo;
      assign use_p[g] = sp;
      assign use_x[g] = sd && (g != 2);
      assign use_y[g] = sd && (g == 2);
      dmrc_ram u_ram
      (
        .mclk    (mclk),
        .we      ((sp && p_wr) || (sd && d_wr)),
        .re      ((sp && p_rd) || (sd && d_rd)),
        .addr    (sp ? p_off[9:0] : d_off[9:0]),
        .wdata   (sp ? p_wdata : d_wd),
        .rdata_q (bank_rd[g*24 +: 24])
      );
    end
  endgenerate

  // remember which bank answers each space
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      psel_q  <= 3'h0;
      xsel_q  <= 3'h0;
      ysel_q  <= 3'h0;
      p_hit_q <= 1'b0;
      x_hit_q <= 1'b0;
      y_hit_q <= 1'b0;
    end
    else
    begin
      psel_q  <= use_p;
      xsel_q  <= use_x;
      ysel_q  <= use_y;
      p_hit_q <= |use_p;
      x_hit_q <= |use_x;
      y_hit_q <= |use_y;
    end
  end

  always @*
  begin
    p_mux = 24'h00_0000;
    x_mux = 24'h00_0000;
    y_mux = 24'h00_0000;
    for (i = 0; i < 3; i = i + 1)
    begin
      if (psel_q[i])
        p_mux = p_mux | bank_rd[i*24 +: 24];
      if (xsel_q[i])
        x_mux = x_mux | bank_rd[i*24 +: 24];
      if (ysel_q[i])
        y_mux = y_mux | bank_rd[i*24 +: 24];
    end
  end

  // read data muxed combinationally from the bank read registers, zero once the select flops clear
  always @*
  begin
    p_rdata_q = p_mux;
    x_rdata_q = x_mux;
    y_rdata_q = y_mux;
  end
endmodule // dmrc_top
`default_nettype wire

// ===== hdl/dmrc_defines.vh
// constants for the dynamic memory remap control block
`ifndef DMRC_DEFINES_VH
`define DMRC_DEFINES_VH
`define DMRC_PE_A_BIT    2
`define DMRC_PE_B_BIT    3
`define DMRC_PE_RST      2'h0
`define DMRC_SWITCH_CYC  2'h3
`define DMRC_BANK_DEPTH  768
`define DMRC_P_LO        16'h0200
`define DMRC_P_HI        16'h0aff
`define DMRC_P_A_LO      16'h0800
`define DMRC_P_A_HI      16'h0aff
`define DMRC_P_B1_LO     16'h0200
`define DMRC_P_B1_HI     16'h04ff
`define DMRC_P_B2_LO     16'h0500
`define DMRC_P_B2_HI     16'h07ff
`define DMRC_X_A_LO      16'h0c00
`define DMRC_X_A_HI      16'h0eff
`define DMRC_X_B_LO      16'h0f00
`define DMRC_X_B_HI      16'h11ff
`define DMRC_Y_B_LO      16'h0e00
`define DMRC_Y_B_HI      16'h10ff
`endif

// ===== hdl/dmrc_ram.v
// single-port ram bank with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "dmrc_defines.vh"
module dmrc_ram
(
  input  wire        mclk,
  input  wire        we,
  input  wire        re,
  input  wire [9:0]  addr,
  input  wire [23:0] wdata,
  output reg  [23:0] rdata_q
);
  reg [23:0] mem [0:`DMRC_BANK_DEPTH-1];

  // contents never touched by remap
  always @(posedge mclk)
  begin
    if (we)
      mem[addr] <= wdata;
    if (re)
      rdata_q <= mem[addr];
  end
endmodule // dmrc_ram
`default_nettype wire

// ===== tb/dmrc_top_asserts.sv
// checker on the remap control ports
`timescale 1ns/10ps
`default_nettype none
module dmrc_chk
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        instr_cycle_en,
  input wire logic        omr_wr,
  input wire logic [23:0] omr_wdata,
  input wire logic [1:0]  operating_mode_reg_pe_q,
  input wire logic [1:0]  map_active_q,
  input wire logic        switch_pending,
  input wire logic [15:0] p_addr,
  input wire logic        p_rd,
  input wire logic        p_hit_q,
  input wire logic [15:0] x_addr,
  input wire logic        x_rd,
  input wire logic        x_hit_q
);
  logic [1:0] cnt_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // pulses seen since the enable write
  always_ff @(posedge mclk)
    if (!rst_n || omr_wr) cnt_q <= 2'b00;
    else if (switch_pending && instr_cycle_en) cnt_q <= cnt_q + 2'b01;
  pend_set_a: assert property (omr_wr |=> switch_pending) else $error("no pending");
  pe_wr_a: assert property (omr_wr |=> operating_mode_reg_pe_q == $past(omr_wdata[3:2]))
    else $error("enable bits");
  map_early_a: assert property (map_active_q != $past(map_active_q) |->
    $past(cnt_q) == 2'b10 && $past(instr_cycle_en)) else $error("map early");
  map_late_a: assert property (switch_pending && instr_cycle_en && cnt_q == 2'b10 &&
    !omr_wr |=> map_active_q == operating_mode_reg_pe_q && !switch_pending) else $error("map late");
  rst_clr_a: assert property (disable iff (1'b0) !rst_n |=>
    operating_mode_reg_pe_q == 2'b00 && map_active_q == 2'b00) else $error("reset");
  p_win_a: assert property (p_rd && p_addr inside {[16'h0800:16'h0aff]} |=>
    p_hit_q == $past(map_active_q[0])) else $error("p hit");
  x_win_a: assert property (x_rd && x_addr inside {[16'h0c00:16'h0eff]} |=>
    x_hit_q == !$past(map_active_q[0])) else $error("x hit");
  p_out_a: assert property (p_rd && !(p_addr inside {[16'h0200:16'h0aff]}) |=> !p_hit_q)
    else $error("p outside");
  cover property ($fell(switch_pending));
  cover property (p_hit_q);
  cover property (x_hit_q);
endmodule // dmrc_chk
bind dmrc_top dmrc_chk chk_u (.*);
`default_nettype wire

// ===== tb/dmrc_core_mdl.sv
// core model giving instruction cycle pulses
`timescale 1ns/10ps
`default_nettype none
module dmrc_core_mdl
(
  input  wire logic mclk,
  input  wire logic go,
  output var  logic instr_cycle_en = 1'b0
);
  // no interrupts modelled
  // never halted inside a switch
  // every second clock while running
  always @(posedge mclk)
    instr_cycle_en <= #1 go && !instr_cycle_en;
endmodule // dmrc_core_mdl
`default_nettype wire

// ===== tb/test_dynamic_memory_remap_control.sv
// bench for the remap control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(v, e) begin n_tests++; if ((v) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h vs %h", $time, v, e); end end
module test_dynamic_memory_remap_control;
  logic        mclk = 0, rst_n = 0, omr_wr = 0, go = 0, ice, pend, p_hit_q, x_hit_q, y_hit_q;
  logic        p_rd = 0, p_wr = 0, x_rd = 0, x_wr = 0, y_rd = 0, y_wr = 0;
  logic [15:0] a = 0;
  logic [23:0] d = 0, omr_wdata = 0, p_rdata_q, x_rdata_q, y_rdata_q;
  logic [1:0]  pe_q, map_q;
  int          fail_count = 0, n_tests = 0;
  dmrc_top dut_u (.mclk, .rst_n, .instr_cycle_en(ice), .omr_wr, .omr_wdata,
    .operating_mode_reg_pe_q(pe_q), .map_active_q(map_q), .switch_pending(pend),
    .p_addr(a), .p_rd, .p_wr, .p_wdata(d), .p_rdata_q, .p_hit_q,
    .x_addr(a), .x_rd, .x_wr, .x_wdata(d), .x_rdata_q, .x_hit_q,
    .y_addr(a), .y_rd, .y_wr, .y_wdata(d), .y_rdata_q, .y_hit_q);
  dmrc_core_mdl core_u (.mclk, .go, .instr_cycle_en(ice));
  initial forever #25 mclk = ~mclk;
  task automatic acc(input [2:0] s, input w, input [15:0] ad, input [23:0] dv, input eh);
    @(posedge mclk) #1;
    {y_wr, y_rd, x_wr, x_rd, p_wr, p_rd} = {3{w, !w}} & {{2{s[2]}}, {2{s[1]}}, {2{s[0]}}};
    a = ad;
    d = dv;
    @(posedge mclk) #1;
    {y_wr, y_rd, x_wr, x_rd, p_wr, p_rd} = 6'h00;
    `CHK(s[0] ? p_hit_q : s[1] ? x_hit_q : y_hit_q, eh)
    if (!w) `CHK(s[0] ? p_rdata_q : s[1] ? x_rdata_q : y_rdata_q, eh ? dv : 24'h00_0000)
  endtask
  // bus stays quiet through the switch cycle
  task automatic sw(input [1:0] v, input [1:0] o);
    @(posedge mclk) #1 omr_wr = 1;
    omr_wdata[3:2] = v;
    @(posedge mclk) #1 omr_wr = 0;
    go = 1;
    repeat (4) @(posedge mclk);
    #1 `CHK({pend, pe_q, map_q}, {1'b1, v, o})
    repeat (2) @(posedge mclk);
    #1 `CHK({pend, map_q}, {1'b0, v})
    go = 0;
  endtask
  task automatic t_keep_a;
    `CHK({pe_q, map_q}, 4'h0)
    acc(3'b010, 1, 16'h0c10, 24'ha5_5a3c, 1);
    sw(2'b01, 2'b00);
    acc(3'b001, 0, 16'h0810, 24'ha5_5a3c, 1);
    acc(3'b010, 0, 16'h0c10, 24'ha5_5a3c, 0);
    acc(3'b001, 0, 16'h0100, 24'h00_0000, 0);
  endtask
  task automatic t_keep_b;
    acc(3'b100, 1, 16'h0e05, 24'h3c_c3e1, 1);
    sw(2'b11, 2'b01);
    acc(3'b001, 0, 16'h0505, 24'h3c_c3e1, 1);
    acc(3'b001, 1, 16'h0811, 24'h0f_f00f, 1);
    acc(3'b100, 0, 16'h0e05, 24'h3c_c3e1, 0);
    sw(2'b00, 2'b11);
    acc(3'b010, 0, 16'h0c11, 24'h0f_f00f, 1);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #20000 fail_count++;
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1;
    t_keep_a;
    t_keep_b;
    conclude;
  end
endmodule // test_dynamic_memory_remap_control
`default_nettype wire
